// ==== common/timer_bus_map.vh ====
// constants for the timer serial bus interface
`ifndef TIMER_BUS_MAP_VH
`define TIMER_BUS_MAP_VH
// bit timing within a 56 bit word
`define LAST_BIT          6'h37
`define FIRST_BIT         6'h00
`define INSTR_FIRST_BIT   6'h2C
`define INSTR_LAST_BIT    6'h35
`define ADDR_LAST_BIT     6'h07
`define DIGIT_LAST_BIT    2'h3
// ten bit instruction codes, six bit peripheral opcode tails and the own address
`define PERIPH_SELECT     10'h3F0
`define STORAGE_SELECT    10'h270
`define POWER_OFF         10'h060
`define WRITE_CLOCK       10'h028
`define READ_CLOCK        10'h038
`define NO_INSTR          10'h000
`define PERIPH_WRITE_LOW  6'h28
`define PERIPH_READ_LOW   6'h38
`define OWN_ADDRESS       8'hFB
// flag digits
`define FLAG_SERVICE      4'hD
`define FLAG_ALARM        4'hC
// timing, in ns and in 10 ns cycles
`define CLOCK_PERIOD_NS   32'h0000000A
`define INCR_PERIOD_NS    32'h00989680
`define DEBOUNCE_NS       32'h00989680
`define INCR_CYCLES       (`INCR_PERIOD_NS / `CLOCK_PERIOD_NS)
`define DEBOUNCE_CYCLES   ((`DEBOUNCE_NS + `CLOCK_PERIOD_NS - 32'h00000001) / `CLOCK_PERIOD_NS)
// synchroniser lanes
`define IN_PH1            0
`define IN_PH2            1
`define IN_ACTIVE         2
`define IN_SYNC           3
`define IN_ISA            4
`define IN_DATA           5
`define IN_PINS           6
// register offsets
`define REG_CLOCK_A       3'h0
`define REG_CLOCK_B       3'h1
`define REG_ALARM_A       3'h2
`define REG_ALARM_B       3'h3
`define REG_CONTROL       3'h4
`define REG_STATUS        3'h5
// control bits
`define CTL_TEST_A        0
`define CTL_TEST_B        1
`define CTL_START         2
`define CTL_STOP          3
// test select codes and the all zero word
`define TEST_ALARM        2'h0
`define TEST_PRESCALE     2'h1
`define TEST_RUN          2'h2
`define WORD_ZERO         56'h0
`endif

// ==== rtl/timer_serial_bus_interface.v ====
// serial system bus side of the two clock timekeeping peripheral
// Functional notes
// - while driving data, hold a valid level for all 56 bits
// - words are always 56 bits; unused bit positions are ignored
// - least significant bit first; 14 digits of four bits ascending
// - flag n is only valid during digit n of the word
// - pull flag low in its digit, then actively drive it high
// - flags other than 13 only driven while selected
// - flag 13 wired-or: pull low only, release at digit end
// - flag 13 asserted on any alarm, selected or not
// - flag 12 asserted on any alarm while chip enable set
// - two clocks, two alarms; alarm valid when alarm equals clock
// - pads show alarms when test selects are zero, else test nodes
// - start and stop pins debounced at least 10 ms
// - start sets run enable, stop clears it, per clock
// - start and stop tied together toggle the run state
// - bus start and stop still work with stuck pins
// - peripheral select then address FB in bits 0-7 sets chip enable
// - peripheral ops ignored unless enabled; other address clears enable
// - storage select clears chip enable whatever the address
// - 10 ms increments deferred to word boundary while bus active
// - after power off the increment happens at once
// - instruction in bits 44-53 applies to the whole next word
// - bit and word counters held in reset while bus inactive
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "timer_bus_map.vh"

module timer_serial_bus_interface #(
  parameter INCR_CYCLES     = `INCR_CYCLES,
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire        clock,                    // system clock, 100 MHz
  input  wire        reset,                    // synchronous, active high
  input  wire        phase1,                   // bus phase 1 clock pin
  input  wire        phase2,                   // bus phase 2 clock pin
  input  wire        bus_active_line,          // high while the bus runs
  input  wire        sync_line,                // instruction time marker
  input  wire        instruction_address_line, // serial instruction input
  input  wire        data_in,                  // data line level
  output reg         data_out,                 // data line drive value
  output reg         data_oe,                  // data line drive enable
  output reg         flag_out,                 // flag line drive value
  output reg         flag_oe,                  // flag line drive enable
  input  wire        start_a,                  // clock a start pin
  input  wire        stop_a,                   // clock a stop pin
  input  wire        start_b,                  // clock b start pin
  input  wire        stop_b,                   // clock b stop pin
  output reg         alarm_a_pad,              // alarm a pad
  output reg         alarm_b_pad,              // alarm b pad
  input  wire [2:0]  reg_addr,                 // register address
  input  wire [55:0] reg_wdata,                // register write data
  input  wire        reg_write,                // write strobe
  input  wire        reg_read,                 // read strobe
  output reg  [55:0] reg_rdata                 // read data, next cycle
);

  localparam [1:0] STOPPED = 2'h1;
  localparam [1:0] RUNNING = 2'h2;
  localparam [19:0] INCR_LAST     = INCR_CYCLES[19:0] - 20'h00001;
  localparam [19:0] DEBOUNCE_LAST = DEBOUNCE_CYCLES[19:0] - 20'h00001;

  // true for the read or write peripheral opcodes
  function is_periph;
    input [9:0] op;
    begin
      is_periph = (op[5:0] == `PERIPH_WRITE_LOW) || (op[5:0] == `PERIPH_READ_LOW);
    end
  endfunction

  // all pins cross into the clock domain through two flops
  wire [9:0] raw_in = {stop_b, start_b, stop_a, start_a, data_in,
                       instruction_address_line, sync_line,
                       bus_active_line, phase2, phase1};
  reg  [9:0] meta_in;
  reg  [9:0] sync_in;

  always @(posedge clock) begin
    if (reset) begin
      meta_in <= 10'h000;
      sync_in <= 10'h000;
    end else begin
      meta_in <= raw_in;
      sync_in <= meta_in;
    end
  end

  wire ph1       = sync_in[`IN_PH1];
  wire ph2       = sync_in[`IN_PH2];
  wire bus_on    = sync_in[`IN_ACTIVE];
  wire sync_bit  = sync_in[`IN_SYNC];
  wire isa_bit   = sync_in[`IN_ISA];
  wire data_bit  = sync_in[`IN_DATA];
  wire [3:0] pin = sync_in[9:6];

  reg ph1_d;
  reg ph2_d;

  always @(posedge clock) begin
    if (reset) begin
      ph1_d <= 1'b0;
      ph2_d <= 1'b0;
    end else begin
      ph1_d <= ph1;
      ph2_d <= ph2;
    end
  end

  // bit boundary on phase 2 rise, inputs sampled on phase 1 fall
  wire bit_edge    = bus_on & ph2 & ~ph2_d;
  wire sample_edge = bus_on & ph1_d & ~ph1;

  reg  [5:0] bit_index;
  wire       word_start = bit_edge & (bit_index == `LAST_BIT);

  always @(posedge clock) begin
    if (reset || !bus_on) begin
      bit_index <= `LAST_BIT;
    end else if (bit_edge) begin
      if (bit_index == `LAST_BIT) begin
        bit_index <= `FIRST_BIT;
      end else begin
        bit_index <= bit_index + 6'h01;
      end
    end
  end

  // instruction capture, lsb first, taking effect from bit 0 onward
  reg [9:0] instr_shift;
  reg       instr_sync;
  reg [9:0] cur_instr;
  wire in_instr = (bit_index >= `INSTR_FIRST_BIT) && (bit_index <= `INSTR_LAST_BIT);
  wire [9:0] next_instr = instr_sync ? instr_shift : `NO_INSTR;

  always @(posedge clock) begin
    if (reset || !bus_on) begin
      instr_shift <= `NO_INSTR;
      instr_sync  <= 1'b0;
      cur_instr   <= `NO_INSTR;
    end else begin
      if (sample_edge && in_instr) begin
        instr_shift <= {isa_bit, instr_shift[9:1]};
        if (bit_index == `INSTR_LAST_BIT) begin
          instr_sync <= sync_bit;
        end
      end
      if (word_start) begin
        cur_instr  <= next_instr;
        instr_sync <= 1'b0;
      end
    end
  end

  // chip enable from the two select instructions
  reg [7:0] addr_shift;
  reg       chip_enable;
  wire in_addr = (bit_index <= `ADDR_LAST_BIT);

  always @(posedge clock) begin
    if (reset) begin
      addr_shift  <= 8'h00;
      chip_enable <= 1'b0;
    end else begin
      if (sample_edge && in_addr && cur_instr == `PERIPH_SELECT) begin
        addr_shift <= {data_bit, addr_shift[7:1]};
      end
      if (bit_edge && bit_index == `ADDR_LAST_BIT && cur_instr == `PERIPH_SELECT) begin
        chip_enable <= (addr_shift == `OWN_ADDRESS);
      end
      if (word_start && next_instr == `STORAGE_SELECT) begin
        chip_enable <= 1'b0;
      end
    end
  end

  wire periph_ok = chip_enable & is_periph(cur_instr);
  wire wr_word   = periph_ok & (cur_instr == `WRITE_CLOCK);

  // power off seen: the bus goes quiet late in the following word
  reg power_off_seen;

  always @(posedge clock) begin
    if (reset || !bus_on) begin
      power_off_seen <= 1'b0;
    end else if (word_start && next_instr == `POWER_OFF) begin
      power_off_seen <= 1'b1;
    end
  end

  // full word receive for a clock write; surplus bits simply land too
  reg [55:0] rx_word;

  always @(posedge clock) begin
    if (reset) begin
      rx_word <= `WORD_ZERO;
    end else if (sample_edge && wr_word) begin
      rx_word <= {data_bit, rx_word[55:1]};
    end
  end

  // 10 ms increment trigger from a prescaler
  reg [19:0] prescale;
  reg        incr_pending;
  wire       tick = (prescale == INCR_LAST);
  // deferral keeps bus transfers and increments apart
  wire       incr_fire = incr_pending & (!bus_on | power_off_seen | word_start);

  always @(posedge clock) begin
    if (reset) begin
      prescale     <= 20'h00000;
      incr_pending <= 1'b0;
    end else begin
      prescale <= tick ? 20'h00000 : prescale + 20'h00001;
      if (tick) begin
        incr_pending <= 1'b1;
      end else if (incr_fire) begin
        incr_pending <= 1'b0;
      end
    end
  end

  // pin debounce: a level must hold for the full period to pass
  reg  [3:0]  pin_level;
  reg  [3:0]  pin_prev;
  wire [3:0]  pin_rise = pin_level & ~pin_prev;

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1) begin : g_debounce
      reg [19:0] stable_count;
      always @(posedge clock) begin
        if (reset) begin
          stable_count  <= 20'h00000;
          pin_level[gp] <= 1'b0;
          pin_prev[gp]  <= 1'b0;
        end else begin
          pin_prev[gp] <= pin_level[gp];
          if (pin[gp] == pin_level[gp]) begin
            stable_count <= 20'h00000;
          end else if (stable_count == DEBOUNCE_LAST) begin
            stable_count  <= 20'h00000;
            pin_level[gp] <= pin[gp];
          end else begin
            stable_count <= stable_count + 20'h00001;
          end
        end
      end
    end
  endgenerate

  // control register: test selects and one-shot start/stop commands
  reg        test_select_a;
  reg        test_select_b;
  reg  [1:0] cmd_start;
  reg  [1:0] cmd_stop;
  wire       ctl_write = reg_write && (reg_addr == `REG_CONTROL);

  always @(posedge clock) begin
    if (reset) begin
      test_select_a <= 1'b0;
      test_select_b <= 1'b0;
      cmd_start     <= 2'h0;
      cmd_stop      <= 2'h0;
    end else begin
      cmd_start <= 2'h0;
      cmd_stop  <= 2'h0;
      if (ctl_write) begin
        test_select_a <= reg_wdata[`CTL_TEST_A];
        test_select_b <= reg_wdata[`CTL_TEST_B];
        cmd_start     <= reg_wdata[`CTL_START+1:`CTL_START];
        cmd_stop      <= reg_wdata[`CTL_STOP+2:`CTL_STOP+1];
      end
    end
  end

  // per clock run state machines, edge driven so stuck pins block nothing
  reg  [1:0] run_state [0:1];
  wire [1:0] run_enable;

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_run
      wire start_edge = pin_rise[2*gc];
      wire stop_edge  = pin_rise[2*gc+1];
      assign run_enable[gc] = (run_state[gc] == RUNNING);
      always @(posedge clock) begin
        if (reset) begin
          run_state[gc] <= STOPPED;
        end else begin
          case (run_state[gc])
            STOPPED: begin
              // a tied pair rises together: this start half toggles on
              if (cmd_start[gc] || start_edge) begin
                run_state[gc] <= RUNNING;
              end
            end
            RUNNING: begin
              if (cmd_stop[gc] || stop_edge) begin
                run_state[gc] <= STOPPED;
              end
            end
            default: begin
              run_state[gc] <= STOPPED;
            end
          endcase
        end
      end
    end
  endgenerate

  wire clock_a_run_enable = run_enable[0];

  // clock and alarm registers; software write beats bus write beats increment
  reg  [55:0] clock_reg [0:1];
  reg  [55:0] alarm_reg [0:1];
  reg  [1:0]  alarm;

  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_time
      wire [2:0] clk_off = gc ? `REG_CLOCK_B : `REG_CLOCK_A;
      wire [2:0] alm_off = gc ? `REG_ALARM_B : `REG_ALARM_A;
      always @(posedge clock) begin
        if (reset) begin
          clock_reg[gc] <= `WORD_ZERO;
          alarm_reg[gc] <= `WORD_ZERO;
          alarm[gc]     <= 1'b0;
        end else begin
          alarm[gc] <= (alarm_reg[gc] == clock_reg[gc]);
          if (reg_write && reg_addr == clk_off) begin
            clock_reg[gc] <= reg_wdata;
          end else if (gc == 0 && sample_edge && bit_index == `LAST_BIT && wr_word) begin
            clock_reg[gc] <= {data_bit, rx_word[55:1]};
          end else if (incr_fire && run_enable[gc]) begin
            clock_reg[gc] <= clock_reg[gc] + 56'h1;
          end
          if (reg_write && reg_addr == alm_off) begin
            alarm_reg[gc] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  wire any_alarm = |alarm;

  // data line: clock a shifted out lsb first across the whole word
  reg [55:0] tx_word;

  always @(posedge clock) begin
    if (reset || !bus_on) begin
      tx_word  <= `WORD_ZERO;
      data_oe  <= 1'b0;
      data_out <= 1'b0;
    end else if (word_start) begin
      tx_word  <= {1'b0, clock_reg[0][55:1]};
      data_out <= clock_reg[0][0];
      data_oe  <= chip_enable && next_instr == `READ_CLOCK;
    end else if (bit_edge) begin
      tx_word  <= {1'b0, tx_word[55:1]};
      data_out <= tx_word[0];
    end
  end

  // flag line multiplexed by digit
  wire [3:0] digit    = bit_index[5:2];
  wire       digit_end = (bit_index[1:0] == `DIGIT_LAST_BIT);

  always @(posedge clock) begin
    if (reset || !bus_on) begin
      flag_oe  <= 1'b0;
      flag_out <= 1'b1;
    end else if (digit == `FLAG_SERVICE && any_alarm && !digit_end) begin
      flag_oe  <= 1'b1;
      flag_out <= 1'b0;
    end else if (digit == `FLAG_ALARM && any_alarm && chip_enable) begin
      flag_oe  <= 1'b1;
      flag_out <= digit_end;
    end else begin
      // flag 13 is only ever released, never driven high
      flag_oe  <= 1'b0;
      flag_out <= 1'b1;
    end
  end

  // alarm pads with test node selection
  wire [1:0] test_code = {test_select_b, test_select_a};

  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_pad
      reg pad_value;
      always @* begin
        pad_value = alarm[gc];
        case (test_code)
          `TEST_ALARM:    pad_value = alarm[gc];
          `TEST_PRESCALE: pad_value = prescale[19];
          `TEST_RUN:      pad_value = run_enable[gc];
          default:        pad_value = incr_fire;
        endcase
      end
    end
  endgenerate

  always @(posedge clock) begin
    if (reset) begin
      alarm_a_pad <= 1'b0;
      alarm_b_pad <= 1'b0;
    end else begin
      alarm_a_pad <= g_pad[0].pad_value;
      alarm_b_pad <= g_pad[1].pad_value;
    end
  end

  // register read port: data valid only in the cycle after the strobe
  reg [55:0] next_rdata;

  always @* begin
    next_rdata = `WORD_ZERO;
    if (reg_addr == `REG_CLOCK_A) begin
      next_rdata = clock_reg[0];
    end else if (reg_addr == `REG_CLOCK_B) begin
      next_rdata = clock_reg[1];
    end else if (reg_addr == `REG_ALARM_A) begin
      next_rdata = alarm_reg[0];
    end else if (reg_addr == `REG_ALARM_B) begin
      next_rdata = alarm_reg[1];
    end else if (reg_addr == `REG_CONTROL) begin
      next_rdata = {54'h0, test_select_b, test_select_a};
    end else if (reg_addr == `REG_STATUS) begin
      next_rdata = {50'h0, power_off_seen, alarm, run_enable[1],
                    clock_a_run_enable, chip_enable};
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= `WORD_ZERO;
    end else begin
      reg_rdata <= reg_read ? next_rdata : `WORD_ZERO;
    end
  end

endmodule

// ==== dv/timer_bus_props.sv ====
// assertions on the serial bus and register ports of the timer interface
`timescale 1ns/1ps
module timer_bus_props #(
  parameter INCR_CYCLES     = 1000000,
  parameter DEBOUNCE_CYCLES = 1000000
) (
  input wire        clock,           // system clock
  input wire        reset,           // synchronous, active high
  input wire        phase1,          // bus phase 1 pin
  input wire        phase2,          // bus phase 2 pin
  input wire        bus_active_line, // bus active
  input wire        data_oe,         // data drive enable
  input wire        flag_out,        // flag drive value
  input wire        flag_oe,         // flag drive enable
  input wire        reg_read,        // read strobe
  input wire [55:0] reg_rdata        // read data
);
  reg       ph1_q;
  reg       ph2_q;
  reg [5:0] bit_idx;
  reg       prev_low12;
  // outputs lag the pins by the sync flops, so they are judged mid bit at the phase 1 fall
  wire      ph1_fall = ph1_q & ~phase1;

  always @(posedge clock) begin
    ph1_q <= phase1;
    ph2_q <= phase2;
    if (reset || !bus_active_line)
      bit_idx <= 6'h37;
    else if (phase2 && !ph2_q)
      bit_idx <= (bit_idx == 6'h37) ? 6'h00 : bit_idx + 6'h01;
    if (ph1_fall)
      prev_low12 <= (bit_idx == 6'h32) && flag_oe && !flag_out;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence low12_s;
    ph1_fall && prev_low12 && bit_idx == 6'h33;
  endsequence
  sequence digit13_drive_s;
    ph1_fall && bit_idx >= 6'h34 && flag_oe;
  endsequence

  flag13_no_high_a: assert property (digit13_drive_s |-> !flag_out)
    else $error("flag driven high in digit 13");
  flag13_release_a: assert property (ph1_fall && bit_idx == 6'h37 |-> !flag_oe)
    else $error("flag still driven in last bit of digit 13");
  flag_digit_a: assert property (ph1_fall && flag_oe |-> bit_idx >= 6'h30 && bit_idx <= 6'h36)
    else $error("flag driven outside digits 12 and 13");
  flag12_low_a: assert property (ph1_fall && flag_oe && bit_idx >= 6'h30 && bit_idx <= 6'h32 |-> !flag_out)
    else $error("flag 12 driven high in its active bits");
  flag12_return_a: assert property (low12_s |-> flag_oe && flag_out)
    else $error("flag 12 not returned high");
  data_rise_a: assert property ($rose(data_oe) |-> bit_idx == 6'h00)
    else $error("data drive started off a word boundary");
  data_fall_a: assert property ($fell(data_oe) |-> bit_idx == 6'h00 || !bus_active_line)
    else $error("data drive ended inside a word");
  idle_bus_a: assert property (!bus_active_line [*4] |-> !data_oe)
    else $error("data driven while bus inactive");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 56'h0)
    else $error("read data not zero outside read cycle");
endmodule

bind timer_serial_bus_interface timer_bus_props #(
  .INCR_CYCLES(INCR_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) props_u (
  .clock(clock), .reset(reset), .phase1(phase1), .phase2(phase2), .bus_active_line(bus_active_line),
  .data_oe(data_oe), .flag_out(flag_out), .flag_oe(flag_oe), .reg_read(reg_read), .reg_rdata(reg_rdata)
);

// ==== dv/cpu_bus_model.sv ====
// behavioural calculator cpu driving the serial system bus
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire clock,                    // system clock
  output reg  phase1,                   // bus phase 1
  output reg  phase2,                   // bus phase 2
  output reg  bus_active_line,          // bus active
  output reg  sync_line,                // instruction marker
  output reg  instruction_address_line, // serial instructions
  output wire data_line,                // resolved data line
  input  wire data_out,                 // device data value
  input  wire data_oe,                  // device data enable
  input  wire flag_out,                 // device flag value
  input  wire flag_oe                   // device flag enable
);
  reg        cpu_bit;
  reg        cpu_en;
  reg        last_level;
  reg [55:0] got;
  reg [55:0] fl_low;
  reg [55:0] fl_high;
  reg        oe_seen;
  // no pull on data: an undriven line shows a changing pattern, never the last value
  assign data_line = data_oe ? data_out : (cpu_en ? cpu_bit : ~last_level);

  initial begin
    phase1 = 1'b0;
    phase2 = 1'b0;
    bus_active_line = 1'b0;
    sync_line = 1'b0;
    instruction_address_line = 1'b0;
    cpu_bit = 1'b0;
    cpu_en = 1'b0;
    last_level = 1'b0;
    oe_seen = 1'b0;
  end

  always @(posedge clock) begin
    last_level <= data_line;
  end

  task bus_on;
    begin
      bus_active_line <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask

  // 16 system clocks a bit; phases stand still between words
  task word(input [9:0] op, input sync_b, input [55:0] dat, input drv, input drop);
    integer k;
    integer c;
    begin
      oe_seen <= 1'b0;
      for (k = 0; k < 56; k = k + 1) begin
        for (c = 0; c < 16; c = c + 1) begin
          @(posedge clock);
          phase2 <= (c < 4);
          phase1 <= (c >= 6 && c < 10);
          if (c == 0) begin
            instruction_address_line <= (k >= 44 && k <= 53) ? op[k-44] : 1'b0;
            sync_line <= (k >= 44 && k <= 53) && sync_b;
            cpu_bit <= dat[k];
            cpu_en <= drv;
            if (drop && k == 54)
              bus_active_line <= 1'b0;
          end
          if (c == 9) begin
            got[k] <= data_line;
            fl_low[k] <= flag_oe & ~flag_out;
            fl_high[k] <= flag_oe & flag_out;
            if (data_oe)
              oe_seen <= 1'b1;
          end
        end
      end
    end
  endtask
endmodule

// ==== dv/timer_serial_bus_interface_bench.sv ====
// self-checking bench for the timer serial bus interface
`timescale 1ns/1ps
`include "timer_bus_map.vh"
module timer_serial_bus_interface_bench;
  localparam [55:0] LOW13  = 56'h70000000000000;
  localparam [55:0] LOW12  = 56'h07000000000000;
  localparam [55:0] HIGH12 = 56'h08000000000000;
  reg         clock;
  reg         reset;
  reg  [3:0]  pins;
  reg  [2:0]  reg_addr;
  reg  [55:0] reg_wdata;
  reg         reg_write;
  reg         reg_read;
  wire [55:0] reg_rdata;
  wire        phase1, phase2, bus_active_line, sync_line, isa_line, data_line;
  wire        data_out, data_oe, flag_out, flag_oe, alarm_a_pad, alarm_b_pad;
  reg  [55:0] v0, v1, v2, v3, v4;
  integer     err_count;
  integer     tests_run;

  timer_serial_bus_interface #(.INCR_CYCLES(50), .DEBOUNCE_CYCLES(8)) dut_u (
    .clock(clock), .reset(reset), .phase1(phase1), .phase2(phase2), .bus_active_line(bus_active_line),
    .sync_line(sync_line), .instruction_address_line(isa_line), .data_in(data_line), .data_out(data_out),
    .data_oe(data_oe), .flag_out(flag_out), .flag_oe(flag_oe), .start_a(pins[0]), .stop_a(pins[1]),
    .start_b(pins[2]), .stop_b(pins[3]), .alarm_a_pad(alarm_a_pad), .alarm_b_pad(alarm_b_pad),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  cpu_bus_model cpu_u (
    .clock(clock), .phase1(phase1), .phase2(phase2), .bus_active_line(bus_active_line), .sync_line(sync_line),
    .instruction_address_line(isa_line), .data_line(data_line), .data_out(data_out), .data_oe(data_oe),
    .flag_out(flag_out), .flag_oe(flag_oe));

  always #5 clock = ~clock;

  task check(input string what, input [55:0] exp, input [55:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // the idle cycle after the strobe keeps back to back writes from reassigning it in one step
  task wr(input [2:0] a, input [55:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
    end
  endtask

  task rd(input [2:0] a, output [55:0] v);
    begin
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      v = reg_rdata;
    end
  endtask

  task stat(input [55:0] mask, input [55:0] exp);
    reg [55:0] v;
    begin
      rd(`REG_STATUS, v);
      check("status", exp, v & mask);
    end
  endtask

  task pins_for(input [3:0] p, input integer n);
    begin
      pins <= p;
      repeat (n) @(posedge clock);
      pins <= 4'h0;
      repeat (20) @(posedge clock);
    end
  endtask

  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    pins = 4'h0;
    reg_addr = 3'h0;
    reg_wdata = `WORD_ZERO;
    reg_write = 1'b0;
    reg_read = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    stat(56'h1F, 56'h18);
    check("pad a", 56'h1, {55'h0, alarm_a_pad});
    check("pad b", 56'h1, {55'h0, alarm_b_pad});
    rd(3'h6, v0);
    check("unmapped", 56'h0, v0);
    wr(3'h7, 56'hFFFFFFFFFFFFFF);
    rd(3'h7, v0);
    check("unmapped", 56'h0, v0);
    wr(`REG_CLOCK_A, 56'h0123456789ABCD);
    repeat (4) @(posedge clock);
    stat(56'h18, 56'h10);
    check("pad a", 56'h0, {55'h0, alarm_a_pad});
    wr(`REG_ALARM_A, 56'h0123456789ABCD);
    repeat (4) @(posedge clock);
    check("pad a", 56'h1, {55'h0, alarm_a_pad});
    wr(`REG_CONTROL, 56'h2);
    repeat (4) @(posedge clock);
    check("pad a", 56'h0, {55'h0, alarm_a_pad});
    rd(`REG_CONTROL, v0);
    check("control", 56'h2, v0 & 56'h3);
    wr(`REG_CONTROL, 56'h0);
    cpu_u.bus_on;
    cpu_u.word(`NO_INSTR, 1'b1, 56'h0, 1'b1, 1'b0);
    check("flag low", LOW13, cpu_u.fl_low);
    check("flag high", 56'h0, cpu_u.fl_high);
    cpu_u.word(`READ_CLOCK, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'h0, 1'b0, 1'b0);
    check("drive off", 56'h0, {55'h0, cpu_u.oe_seen});
    cpu_u.word(`PERIPH_SELECT, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'hFB, 1'b1, 1'b0);
    stat(56'h1, 56'h1);
    check("flag low", LOW12 | LOW13, cpu_u.fl_low);
    check("flag high", HIGH12, cpu_u.fl_high);
    cpu_u.word(`READ_CLOCK, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'h0, 1'b0, 1'b0);
    check("read word", 56'h0123456789ABCD, cpu_u.got);
    cpu_u.word(`WRITE_CLOCK, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'h80FEDCBA987654, 1'b1, 1'b0);
    rd(`REG_CLOCK_A, v0);
    check("write word", 56'h80FEDCBA987654, v0);
    cpu_u.word(`WRITE_CLOCK, 1'b0, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'h11111111111111, 1'b1, 1'b0);
    rd(`REG_CLOCK_A, v0);
    check("no sync", 56'h80FEDCBA987654, v0);
    cpu_u.word(`PERIPH_SELECT, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'hFA, 1'b1, 1'b0);
    stat(56'h1, 56'h0);
    cpu_u.word(`PERIPH_SELECT, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'hFB, 1'b1, 1'b0);
    stat(56'h1, 56'h1);
    cpu_u.word(`STORAGE_SELECT, 1'b1, 56'h0, 1'b1, 1'b0);
    cpu_u.word(`NO_INSTR, 1'b1, 56'hFB, 1'b1, 1'b0);
    stat(56'h1, 56'h0);
    // no increments while the bus is active but no word runs
    wr(`REG_CONTROL, 56'h4);
    stat(56'h2, 56'h2);
    rd(`REG_CLOCK_A, v0);
    repeat (300) @(posedge clock);
    rd(`REG_CLOCK_A, v1);
    check("deferred", v0, v1);
    cpu_u.word(`NO_INSTR, 1'b1, 56'h0, 1'b1, 1'b0);
    rd(`REG_CLOCK_A, v2);
    check("word incr", 56'h1, {55'h0, (v2 - v1) >= 56'h1 && (v2 - v1) <= 56'h2});
    cpu_u.word(`POWER_OFF, 1'b1, 56'h0, 1'b1, 1'b0);
    rd(`REG_CLOCK_A, v3);
    cpu_u.word(`NO_INSTR, 1'b1, 56'h0, 1'b1, 1'b1);
    rd(`REG_CLOCK_A, v4);
    check("off incr", 56'h1, {55'h0, (v4 - v3) >= 56'hA});
    wr(`REG_CONTROL, 56'h10);
    stat(56'h6, 56'h0);
    // start and stop pins with the bus idle
    pins_for(4'h1, 20);
    stat(56'h6, 56'h2);
    pins_for(4'h2, 4);
    stat(56'h6, 56'h2);
    pins_for(4'h2, 20);
    stat(56'h6, 56'h0);
    pins_for(4'hC, 20);
    stat(56'h6, 56'h4);
    pins_for(4'hC, 20);
    stat(56'h6, 56'h0);
    pins <= 4'h1;
    repeat (20) @(posedge clock);
    stat(56'h2, 56'h2);
    wr(`REG_CONTROL, 56'h10);
    stat(56'h2, 56'h0);
    pins <= 4'h0;
    repeat (4) @(posedge clock);
    tally_and_finish;
  end

  initial begin
    repeat (80000) @(posedge clock);
    err_count = err_count + 1;
    tally_and_finish;
  end
endmodule
